//--- ppr_port_rx.v
// Printer side of a host parallel port with receive buffer
`include "ppr_defines.vh"
`default_nettype none

// Notes on behaviour
// [R1] A strobe from the host makes the device capture the data lines.
// [R2] In compatibility mode each strobe carries one whole 8-bit byte.
// [R3] In compatibility mode acknowledge is pulsed once a received byte has been taken in.
// [R4] Busy stays high during processing, alarm and while unable to accept, except in nibble mode where it is held low.
// [R5] Fault shows paper out or alarm; paper end shows paper out.
// [R6] Autofeed and select-in are watched to negotiate a mode change.
// [R7] Compatibility, nibble and ECP modes each use their own handshake.
// [R8] Every compatibility-mode byte and ECP data byte goes to the buffer and busy keeps it from overflow.
// [R9] Buffer capacity is one of five settings that set the full threshold.
// [R10] When enabled, an initialise pulse from the host resets the interface.
// [R11] The online switch toggles online state, shown on the select output.
// [R12] Busy rises on a strobe and falls only after that byte's acknowledge, or after the strobe ends in ECP mode.
module ppr_port_rx #(
  parameter ADDR_W = 20
) (
  input wire core_clk,
  input wire reset_n,
  input wire ce,
  input wire [7:0] hostData,
  input wire strobeN,
  input wire autofeedN,
  input wire selectIn,
  input wire initN,
  input wire onlineSw,
  input wire paperOut,
  input wire alarm,
  input wire initEnable,
  input wire [2:0] bufSizeSel,
  input wire outReady,
  output reg [7:0] outData_q,
  output reg outValid_q,
  output reg ackN_q,
  output reg busy_q,
  output reg paperEnd_q,
  output reg select_q,
  output reg faultN_q,
  output reg [4:0] mode_q
);

  localparam [4:0] M_COMPAT = 5'h01;
  localparam [4:0] M_NEG1 = 5'h02;
  localparam [4:0] M_NEG2 = 5'h04;
  localparam [4:0] M_NIB = 5'h08;
  localparam [4:0] M_ECP = 5'h10;

  localparam [2:0] X_IDLE = 3'h1;
  localparam [2:0] X_STRB = 3'h2;
  localparam [2:0] X_ACK = 3'h4;

  localparam CNT_W = ADDR_W + 1;
  localparam [`PPR_ACK_CNT_W-1:0] ACK_CYC = `PPR_ACK_CYC;

  wire [12:0] syncBus;
  wire [7:0] sData;
  wire sStrobeN;
  wire sAutofeedN;
  wire sSelectIn;
  wire sInitN;
  wire sOnlineSw;
  wire [7:0] memQ;

  ppr_sync #(
    .W(13)
  ) uSync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .ce(ce),
    .asyncIn({onlineSw, initN, selectIn, autofeedN, strobeN, hostData}),
    .syncOut(syncBus)
  );

  assign sData = syncBus[7:0];
  assign sStrobeN = syncBus[8];
  assign sAutofeedN = syncBus[9];
  assign sSelectIn = syncBus[10];
  assign sInitN = syncBus[11];
  assign sOnlineSw = syncBus[12];

  reg [2:0] xfer_q;
  reg [2:0] xfer_d;
  reg [4:0] mode_d;
  reg [`PPR_ACK_CNT_W-1:0] ackCnt_q;
  reg [`PPR_ACK_CNT_W-1:0] ackCnt_d;
  reg online_q;
  reg strPrev_q;
  reg initPrev_q;
  reg swPrev_q;
  reg [ADDR_W-1:0] wrPtr_q;
  reg [ADDR_W-1:0] rdPtr_q;
  reg [CNT_W-1:0] count_q;
  reg rdPend_q;
  reg ackN_d;
  reg busy_d;
  reg paperEnd_d;
  reg select_d;
  reg wrEn;
  reg [`PPR_CAP_W-1:0] capSel;

  wire strFall = strPrev_q & ~sStrobeN;
  wire strRise = ~strPrev_q & sStrobeN;
  wire swRise = ~swPrev_q & sOnlineSw;
  // [R10] Initialise gated by config
  wire initHit = initEnable & initPrev_q & ~sInitN;
  wire rdEn = (count_q != {CNT_W{1'b0}}) & ~rdPend_q & ~outValid_q;

  // [R9] Threshold from capacity setting
  always @*
  begin
    case (bufSizeSel)
      `PPR_SEL_8K: capSel = `PPR_CAP_8K;
      `PPR_SEL_20K: capSel = `PPR_CAP_20K;
      `PPR_SEL_50K: capSel = `PPR_CAP_50K;
      `PPR_SEL_100K: capSel = `PPR_CAP_100K;
      `PPR_SEL_1M: capSel = `PPR_CAP_1M;
      default: capSel = `PPR_CAP_8K;
    endcase
  end

  // Also full at the physical depth, should it be smaller
  wire [`PPR_CAP_W+1:0] cntWide = {{(`PPR_CAP_W + 2 - CNT_W){1'b0}}, count_q};
  wire full = (cntWide >= {2'b00, capSel}) | count_q[CNT_W-1];

  // Mode negotiation and transfer handshakes
  always @*
  begin
    mode_d = mode_q;
    xfer_d = xfer_q;
    ackCnt_d = ackCnt_q;
    wrEn = 1'b0;
    case (mode_q)
      M_COMPAT:
      begin
        // [R6] Negotiation request seen
        if (sSelectIn & ~sAutofeedN & (xfer_q == X_IDLE))
          mode_d = M_NEG1;
      end
      M_NEG1:
      begin
        // [R6] Extensibility byte latched
        if (strRise)
        begin
          if (sData == `PPR_EXT_ECP)
            mode_d = M_NEG2 | M_ECP;
          else if (sData == `PPR_EXT_NIBBLE)
            mode_d = M_NEG2 | M_NIB;
          else
            mode_d = M_COMPAT;
        end
      end
      M_NEG2 | M_ECP, M_NEG2 | M_NIB:
      begin
        if (sAutofeedN)
          mode_d = mode_q & ~M_NEG2;
      end
      M_NIB, M_ECP:
      begin
        // [R7] Leaving any extended mode
        if (~sSelectIn)
          mode_d = M_COMPAT;
      end
      default: mode_d = M_COMPAT;
    endcase

    case (xfer_q)
      X_IDLE:
      begin
        // [R1] Capture on strobe
        if (strFall & ((mode_q == M_COMPAT) | (mode_q == M_ECP)))
        begin
          xfer_d = X_STRB;
          // [R8] Store byte unless full; ECP commands dropped
          wrEn = ~full & ((mode_q == M_COMPAT) | sAutofeedN);
        end
      end
      X_STRB:
      begin
        if (strRise)
        begin
          // [R7] ECP has no acknowledge pulse
          if (mode_q == M_COMPAT)
          begin
            xfer_d = X_ACK;
            ackCnt_d = ACK_CYC;
          end
          else
            xfer_d = X_IDLE;
        end
      end
      X_ACK:
      begin
        // [R3] Acknowledge pulse width
        if (ackCnt_q == {`PPR_ACK_CNT_W{1'b0}})
          xfer_d = X_IDLE;
        else
          ackCnt_d = ackCnt_q - 1'b1;
      end
      default: xfer_d = X_IDLE;
    endcase

    if (initHit)
    begin
      mode_d = M_COMPAT;
      xfer_d = X_IDLE;
      wrEn = 1'b0;
    end
  end

  // Port status lines
  always @*
  begin
    // [R3] Acknowledge low during pulse
    ackN_d = ~((xfer_d == X_ACK) & (ackCnt_d != {`PPR_ACK_CNT_W{1'b0}}));
    // [R12] Busy from strobe until ack done, or until strobe release in ECP
    busy_d = (xfer_d != X_IDLE) | strFall;
    // [R4] Busy for alarm, offline or full
    busy_d = busy_d | alarm | ~online_q | full;
    // [R5] Paper end on paper out
    paperEnd_d = paperOut;
    // [R11] Select follows online state
    select_d = online_q;
    case (mode_d)
      M_NEG1:
      begin
        ackN_d = 1'b0;
        paperEnd_d = 1'b1;
        select_d = 1'b1;
      end
      M_NEG2 | M_ECP, M_NEG2 | M_NIB:
        select_d = 1'b1;
      M_NIB:
      begin
        // [R7] Nibble reply echoes the host request
        ackN_d = sAutofeedN;
        busy_d = 1'b0;
      end
      default:
      begin
      end
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      mode_q <= M_COMPAT;
      xfer_q <= X_IDLE;
      ackCnt_q <= {`PPR_ACK_CNT_W{1'b0}};
      online_q <= `PPR_RST_ONLINE;
      strPrev_q <= 1'b1;
      initPrev_q <= 1'b1;
      swPrev_q <= 1'b1;
      wrPtr_q <= {ADDR_W{1'b0}};
      rdPtr_q <= {ADDR_W{1'b0}};
      count_q <= {CNT_W{1'b0}};
      rdPend_q <= 1'b0;
      outData_q <= 8'h00;
      outValid_q <= 1'b0;
      ackN_q <= `PPR_RST_ACK_N;
      busy_q <= `PPR_RST_BUSY;
      paperEnd_q <= 1'b0;
      select_q <= 1'b0;
      faultN_q <= 1'b1;
    end
    else if (ce)
    begin
      mode_q <= mode_d;
      xfer_q <= xfer_d;
      ackCnt_q <= ackCnt_d;
      strPrev_q <= sStrobeN;
      initPrev_q <= sInitN;
      swPrev_q <= sOnlineSw;
      // [R11] Online toggle
      if (swRise)
        online_q <= ~online_q;
      ackN_q <= ackN_d;
      busy_q <= busy_d;
      paperEnd_q <= paperEnd_d;
      select_q <= select_d;
      // [R5] Fault on paper out or alarm
      faultN_q <= ~(paperOut | alarm);
      // [R10] Flush buffer on initialise
      if (initHit)
      begin
        wrPtr_q <= {ADDR_W{1'b0}};
        rdPtr_q <= {ADDR_W{1'b0}};
        count_q <= {CNT_W{1'b0}};
        rdPend_q <= 1'b0;
        outValid_q <= 1'b0;
      end
      else
      begin
        // [R8] Buffer occupancy
        if (wrEn)
          wrPtr_q <= wrPtr_q + 1'b1;
        if (rdEn)
          rdPtr_q <= rdPtr_q + 1'b1;
        if (wrEn & ~rdEn)
          count_q <= count_q + 1'b1;
        else if (~wrEn & rdEn)
          count_q <= count_q - 1'b1;
        rdPend_q <= rdEn;
        if (rdPend_q)
        begin
          outData_q <= memQ;
          outValid_q <= 1'b1;
        end
        else if (outReady)
          outValid_q <= 1'b0;
      end
    end
  end

  // [R2] Whole byte per strobe
  ppr_mem #(
    .ADDR_W(ADDR_W)
  ) uMem (
    .core_clk(core_clk),
    .ce(ce),
    .wrEn(wrEn & ce),
    .wrAddr(wrPtr_q),
    .wrData(sData),
    .rdEn(rdEn & ~initHit),
    .rdAddr(rdPtr_q),
    .rdData(memQ)
  );

endmodule

`default_nettype wire

//--- ppr_defines.vh
// Constants for the printer parallel port receiver
`ifndef PPR_DEFINES_VH
`define PPR_DEFINES_VH

// Main clock period and acknowledge pulse width
`define PPR_CLK_NS 20
`define PPR_ACK_NS 1000
// Sized for the ack counter: 1000 ns at 20 ns
`define PPR_ACK_CYC 8'h32
`define PPR_ACK_CNT_W 8

// Receive buffer capacity settings, in bytes
`define PPR_CAP_W 21
`define PPR_CAP_8K 21'h002000
`define PPR_CAP_20K 21'h005000
`define PPR_CAP_50K 21'h00C800
`define PPR_CAP_100K 21'h019000
`define PPR_CAP_1M 21'h100000

// Capacity select codes
`define PPR_SEL_8K 3'h0
`define PPR_SEL_20K 3'h1
`define PPR_SEL_50K 3'h2
`define PPR_SEL_100K 3'h3
`define PPR_SEL_1M 3'h4

// Extensibility request bytes seen during negotiation
`define PPR_EXT_NIBBLE 8'h00
`define PPR_EXT_ECP 8'h10

// Reset values of the online state and the port outputs
`define PPR_RST_ONLINE 1'b1
`define PPR_RST_ACK_N 1'b1
`define PPR_RST_BUSY 1'b1

`endif

//--- ppr_sync.v
// Two-flop synchroniser bank for the port pins
`default_nettype none

module ppr_sync #(
  parameter W = 8
) (
  input wire core_clk,
  input wire reset_n,
  input wire ce,
  input wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : gBit
      reg meta_q;
      reg stable_q;
      always @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          meta_q <= 1'b1;
          stable_q <= 1'b1;
        end
        else if (ce)
        begin
          meta_q <= asyncIn[i];
          stable_q <= meta_q;
        end
      end
      assign syncOut[i] = stable_q;
    end
  endgenerate

endmodule

`default_nettype wire

//--- ppr_mem.v
// Receive buffer storage with registered read data
`default_nettype none

module ppr_mem #(
  parameter ADDR_W = 20
) (
  input wire core_clk,
  input wire ce,
  input wire wrEn,
  input wire [ADDR_W-1:0] wrAddr,
  input wire [7:0] wrData,
  input wire rdEn,
  input wire [ADDR_W-1:0] rdAddr,
  output reg [7:0] rdData
);

  reg [7:0] store [0:(1 << ADDR_W) - 1];

  // Storage content needs no reset; pointers guard it
  always @(posedge core_clk)
  begin
    if (ce)
    begin
      if (wrEn)
        store[wrAddr] <= wrData;
      if (rdEn)
        rdData <= store[rdAddr];
    end
  end

endmodule

`default_nettype wire

//--- ppr_port_rx_props.sv
// Checker for the printer port receiver
`include "ppr_defines.vh"
`default_nettype none
module ppr_port_rx_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic onlineSw,
  input wire logic paperOut,
  input wire logic alarm,
  input wire logic outReady,
  input wire logic [7:0] outData_q,
  input wire logic outValid_q,
  input wire logic ackN_q,
  input wire logic busy_q,
  input wire logic paperEnd_q,
  input wire logic select_q,
  input wire logic faultN_q,
  input wire logic [4:0] mode_q
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ACKM = `PPR_ACK_CYC - 1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  a_fault_set: assert property (ce && (paperOut || alarm) |=>
    !faultN_q) else $error("fault not shown");
  a_paper_end: assert property (ce && paperOut |=> paperEnd_q)
    else $error("paper end not shown");
  a_alarm_busy: assert property (ce && alarm && mode_q == 5'h01 |=>
    busy_q) else $error("busy low in alarm");
  a_ack_width: assert property ($fell(ackN_q) && mode_q == 5'h01 |->
    ##ACKM !ackN_q ##1 ackN_q) else $error("ack width wrong");
  a_ack_busy: assert property (!ackN_q && mode_q == 5'h01 |-> busy_q)
    else $error("busy low during ack");
  a_busy_release: assert property ($rose(ackN_q) &&
    $past(mode_q) == 5'h01 |-> busy_q) else $error("busy fell early");
  a_offline_busy: assert property (!select_q && !$past(select_q) &&
    mode_q == 5'h01 |-> busy_q) else $error("busy low offline");
  a_online_toggle: assert property (ce && $rose(onlineSw) &&
    mode_q == 5'h01 |-> ##[1:6] $changed(select_q)) else $error("no toggle");
  a_nibble_busy: assert property (mode_q == 5'h08 |-> !busy_q)
    else $error("busy in nibble");
  a_neg_reply: assert property (mode_q == 5'h02 |->
    !ackN_q && select_q && paperEnd_q) else $error("bad negotiation reply");
  a_drain_hold: assert property (outValid_q && !outReady |=>
    outValid_q && $stable(outData_q)) else $error("byte lost");
  c_ack: cover property ($fell(ackN_q));
  c_ecp: cover property (mode_q == 5'h10);
  c_nib: cover property (mode_q == 5'h08);
endmodule
bind ppr_port_rx ppr_port_rx_props i_ppr_port_rx_props (.core_clk, .reset_n,
  .ce, .onlineSw, .paperOut, .alarm, .outReady, .outData_q, .outValid_q,
  .ackN_q, .busy_q, .paperEnd_q, .select_q, .faultN_q, .mode_q);
`default_nettype wire

//--- ppr_host_model.sv
// Host side model of the parallel port
`default_nettype none
module ppr_host_model (
  input wire logic core_clk,
  input wire logic ackN,
  input wire logic busy,
  output logic [7:0] hostData,
  output logic strobeN,
  output logic autofeedN,
  output logic selectIn,
  output logic initN
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    hostData = 8'h00;
    strobeN = 1'b1;
    autofeedN = 1'b1;
    selectIn = 1'b0;
    initN = 1'b1;
  end
  // Bounded so a dead port cannot hang; expiries are counted
  int timeouts = 0;
  task automatic waitSig(input logic useBusy, input logic lvl);
    int n = 0;
    while ((useBusy ? busy : ackN) !== lvl && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 400)
      timeouts++;
  endtask
  task automatic pulse(input logic [7:0] b, input int w);
    hostData = b;
    repeat (4) @(negedge core_clk);
    strobeN = 1'b0;
    repeat (w) @(negedge core_clk);
    strobeN = 1'b1;
  endtask
  task automatic sendByte(input logic [7:0] b, input int w);
    waitSig(1'b1, 1'b0);
    pulse(b, w);
    waitSig(1'b0, 1'b0);
    waitSig(1'b0, 1'b1);
    hostData = ~b;
  endtask
  task automatic negotiate(input logic [7:0] ext);
    selectIn = 1'b1;
    autofeedN = 1'b0;
    waitSig(1'b0, 1'b0);
    pulse(ext, 4);
    repeat (6) @(negedge core_clk);
    autofeedN = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic ecpByte(input logic [7:0] b, input logic cmd);
    autofeedN = !cmd;
    waitSig(1'b1, 1'b0);
    pulse(b, 4);
    waitSig(1'b1, 1'b0);
    autofeedN = 1'b1;
  endtask
  // Init keeps select-in high so only init can end the mode
  task automatic leave(input logic viaInit);
    initN = !viaInit;
    if (!viaInit)
      selectIn = 1'b0;
    autofeedN = 1'b1;
    repeat (6) @(negedge core_clk);
    initN = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- ppr_port_rx_tb.sv
// Testbench for the printer port receiver
`default_nettype none
module ppr_port_rx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n, ce, onlineSw, paperOut, alarm, initEnable;
  logic outReady, stall, full;
  logic [2:0] bufSizeSel;
  logic [31:0] seed = 32'hA623AD9E;
  wire logic [7:0] hostData, outData_q;
  wire logic strobeN, autofeedN, selectIn, initN, outValid_q, ackN_q;
  wire logic busy_q, paperEnd_q, select_q, faultN_q;
  wire logic [4:0] mode_q;
  logic [7:0] expQ[$];
  logic [7:0] ext[2] = '{8'h10, 8'h00};
  logic [4:0] md[2] = '{5'h10, 5'h08};
  int error_cnt = 0;
  int tests_run = 0;
  int k;
  ppr_port_rx #(.ADDR_W(4)) i_ppr_port_rx (.core_clk, .reset_n, .ce,
    .hostData, .strobeN, .autofeedN, .selectIn, .initN, .onlineSw,
    .paperOut, .alarm, .initEnable, .bufSizeSel, .outReady, .outData_q,
    .outValid_q, .ackN_q, .busy_q, .paperEnd_q, .select_q, .faultN_q,
    .mode_q);
  ppr_host_model i_ppr_host_model (.core_clk, .ackN(ackN_q), .busy(busy_q),
    .hostData, .strobeN, .autofeedN, .selectIn, .initN);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic send(input logic [7:0] b);
    expQ.push_back(b);
    i_ppr_host_model.sendByte(b, 3 + seed[10:8]);
  endtask
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  // Random drain stalls the user side
  always @(negedge core_clk)
  begin
    seed <= lfsr(seed);
    outReady <= !stall && seed[0];
  end
  always @(posedge core_clk)
    if (outValid_q === 1'b1 && outReady === 1'b1)
      chk("outData", outData_q, expQ.pop_front());
  initial
  begin
    // Several times the expected run length
    #400000;
    error_cnt++;
    complete_run;
  end
  initial
  begin
    reset_n = 1'b0;
    ce = 1'b1;
    onlineSw = 1'b0;
    paperOut = 1'b0;
    alarm = 1'b0;
    initEnable = 1'b1;
    stall = 1'b0;
    outReady = 1'b0;
    bufSizeSel = 3'h0;
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    for (k = 0; k < 6; k++)
      send(seed[7:0]);
    bufSizeSel = seed[2:0];
    stall = 1'b1;
    full = 1'b0;
    // Sixteen buffered plus one in the output register
    for (k = 0; k < 20 && !full; k++)
    begin
      send(seed[7:0]);
      repeat (100) @(negedge core_clk);
      full = busy_q;
    end
    chk("fill", k, 17);
    stall = 1'b0;
    repeat (300) @(negedge core_clk);
    chk("left", expQ.size(), 0);
    paperOut = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("faultN", faultN_q, 0);
    chk("paperEnd", paperEnd_q, 1);
    paperOut = 1'b0;
    alarm = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("busy", busy_q, 1);
    alarm = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("faultN", faultN_q, 1);
    for (k = 0; k < 2; k++)
    begin
      onlineSw = 1'b1;
      repeat (8) @(negedge core_clk);
      onlineSw = 1'b0;
      repeat (8) @(negedge core_clk);
      chk("select", select_q, k[0]);
    end
    for (k = 0; k < 2; k++)
    begin
      i_ppr_host_model.negotiate(ext[k]);
      chk("mode", mode_q, md[k]);
      i_ppr_host_model.leave(1'b0);
      chk("mode", mode_q, 5'h01);
    end
    i_ppr_host_model.negotiate(8'h10);
    // ECP data byte kept, command byte dropped
    expQ.push_back(8'hC3);
    i_ppr_host_model.ecpByte(8'hC3, 1'b0);
    i_ppr_host_model.ecpByte(8'h3C, 1'b1);
    repeat (40) @(negedge core_clk);
    chk("ecpLeft", expQ.size(), 0);
    initEnable = 1'b0;
    i_ppr_host_model.leave(1'b1);
    chk("mode", mode_q, 5'h10);
    initEnable = 1'b1;
    i_ppr_host_model.leave(1'b1);
    chk("mode", mode_q, 5'h01);
    i_ppr_host_model.leave(1'b0);
    chk("hostWait", i_ppr_host_model.timeouts, 0);
    complete_run;
  end
endmodule
`default_nettype wire
